// File: pkg/hport_pkg.sv
// package: constants, types and overview for the host access port
package hport_pkg;
	localparam int          ADDR_W    = 5;
	localparam int          DATA_W    = 8;
	localparam int          MEM_DEPTH = 32;
	localparam int          IRQ_N     = 3;
	localparam logic [4:0]  CMD_BITS  = 5'h08;
	localparam logic [4:0]  FRAME_END = 5'h10;
	localparam logic [4:0]  CNT_RST   = 5'h00;
	localparam logic [7:0]  BYTE_RST  = 8'h00;
	localparam logic [4:0]  ADDR_RST  = 5'h00;
	// synchroniser layout: mode pins, strobes, shared bus, address bus
	localparam int          SYNC_W    = 20;
	localparam int          B_HW      = 19;
	localparam int          B_SER     = 18;
	localparam int          B_STY     = 17;
	localparam int          B_MUX     = 16;
	localparam int          B_LAT     = 15;
	localparam int          B_RD      = 14;
	localparam int          B_WR      = 13;
	localparam int          B_AD      = 5;
	// strobes idle high so release after reset shows no false edge
	localparam logic [19:0] SYNC_RST  = 20'h0E000;
	typedef enum logic [1:0] {
		P_IDLE  = 2'b00,
		P_READ  = 2'b01,
		P_DRIVE = 2'b10,
		P_WRITE = 2'b11
	} pstate_t;
endpackage

// File: pkg/mem_if.sv
// interface: register store port between the host port and its memory
`timescale 1ns/1ns
`default_nettype none
interface mem_if;
	logic                         we;
	logic                         re;
	logic [hport_pkg::ADDR_W-1:0] addr;
	logic [hport_pkg::DATA_W-1:0] wdata;
	logic [hport_pkg::DATA_W-1:0] rdata;
	modport ctrl (output we, re, addr, wdata, input rdata);
	modport store (input we, re, addr, wdata, output rdata);
endinterface
`default_nettype wire

// File: rtl/reg_mem.sv
// module: small register store with registered read data
`timescale 1ns/1ns
`default_nettype none
module reg_mem #(
	parameter int DEPTH = hport_pkg::MEM_DEPTH
) (
	input  wire logic clk_in,
	input  wire logic rstn_in,
	mem_if.store      bus
);
	logic [hport_pkg::DATA_W-1:0] mem_q [0:DEPTH-1];
	logic [hport_pkg::DATA_W-1:0] rd_q;
	logic [hport_pkg::DATA_W-1:0] rd_d;

	// read data only moves on a read, so it can sit on the bus for a whole cycle
	always_comb begin
		rd_d = rd_q;
		if (bus.re) begin
			rd_d = mem_q[bus.addr];
		end
		if (!rstn_in) begin
			rd_d = hport_pkg::BYTE_RST;
		end
	end

	// array has no reset; contents are undefined until written
	always_ff @(posedge clk_in) begin
		rd_q <= rd_d;
		if (bus.we) begin
			mem_q[bus.addr] <= bus.wdata;
		end
	end

	assign bus.rdata = rd_q;
endmodule // reg_mem
`default_nettype wire

// File: rtl/host_port.sv
// module: host access port with serial shift path and two parallel strobe styles
`timescale 1ns/1ns
`default_nettype none
module host_port (
	input  wire logic        CLK_IN,
	input  wire logic        RESETN_IN,
	input  wire logic        HW_MODE_IN,
	input  wire logic        SERIAL_MODE_IN,
	input  wire logic        STROBE_STYLE_IN,
	input  wire logic        BUS_MUX_SELECT_IN,
	input  wire logic        SHIFT_CLK_IN,
	input  wire logic        SERIAL_CS_N_IN,
	input  wire logic        SERIAL_IN_LINE_IN,
	input  wire logic        EDGE_SELECT_PIN_IN,
	input  wire logic        ADDR_LATCH_IN,
	input  wire logic        RD_RW_IN,
	input  wire logic        WRITE_OR_DATA_STROBE_N_IN,
	input  wire logic [7:0]  AD_IN,
	input  wire logic [4:0]  ADDR_IN,
	input  wire logic [2:0]  IRQ_SRC_IN,
	output logic      [7:0]  AD_OUT,
	output logic             AD_OE_OUT,
	output logic             SERIAL_OUT_LINE_OUT,
	output logic             SERIAL_OUT_LINE_OE_OUT,
	output logic             READY_ACK_OUT,
	output logic             INT_N_OUT,
	output logic             INT_N_OE_OUT
);
	localparam int SW = hport_pkg::SYNC_W;

	mem_if mi ();

	reg_mem u_mem (
		.clk_in  (CLK_IN),
		.rstn_in (RESETN_IN),
		.bus     (mi.store)
	);

	// core side: pin synchroniser, edge detect stage behind it
	logic [SW-1:0] s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;

	always_comb begin
		s1_d = {HW_MODE_IN, SERIAL_MODE_IN, STROBE_STYLE_IN, BUS_MUX_SELECT_IN, ADDR_LATCH_IN,
			RD_RW_IN, WRITE_OR_DATA_STROBE_N_IN, AD_IN, ADDR_IN};
		s2_d = s1_q;
		s3_d = s2_q;
		if (!RESETN_IN) begin
			s1_d = hport_pkg::SYNC_RST;
			s2_d = hport_pkg::SYNC_RST;
			s3_d = hport_pkg::SYNC_RST;
		end
	end

	always_ff @(posedge CLK_IN) begin
		s1_q <= s1_d;
		s2_q <= s2_d;
		s3_q <= s3_d;
	end

	// decoded modes and strobe edges, all from the second stage onward
	logic       hw_m, ser_m, dstb_m, mux_m, par_on, rw;
	logic       lat_fall, rd_fall, rd_rise, wr_fall, wr_rise, dstb_fall, dstb_rise;
	logic [7:0] ad_s;
	logic [4:0] addr_s;

	assign hw_m      = s2_q[hport_pkg::B_HW];
	assign ser_m     = s2_q[hport_pkg::B_SER];
	assign dstb_m    = s2_q[hport_pkg::B_STY];
	assign mux_m     = s2_q[hport_pkg::B_MUX];
	assign rw        = s2_q[hport_pkg::B_RD];
	assign ad_s      = s2_q[hport_pkg::B_AD+7:hport_pkg::B_AD];
	assign addr_s    = s2_q[4:0];
	assign par_on    = !hw_m && !ser_m;
	assign lat_fall  = par_on && mux_m && s3_q[hport_pkg::B_LAT] && !s2_q[hport_pkg::B_LAT];
	assign rd_fall   = par_on && !dstb_m && s3_q[hport_pkg::B_RD] && !s2_q[hport_pkg::B_RD];
	assign rd_rise   = par_on && !dstb_m && !s3_q[hport_pkg::B_RD] && s2_q[hport_pkg::B_RD];
	assign wr_fall   = par_on && !dstb_m && s3_q[hport_pkg::B_WR] && !s2_q[hport_pkg::B_WR];
	assign wr_rise   = par_on && !dstb_m && !s3_q[hport_pkg::B_WR] && s2_q[hport_pkg::B_WR];
	assign dstb_fall = par_on && dstb_m && s3_q[hport_pkg::B_WR] && !s2_q[hport_pkg::B_WR];
	assign dstb_rise = par_on && dstb_m && !s3_q[hport_pkg::B_WR] && s2_q[hport_pkg::B_WR];

	// serial request toggle crossing in from the shift clock
	logic       rq1_q, rq1_d, rq2_q, rq2_d, rq3_q, rq3_d;
	logic       ack_q, ack_d, pend_q, pend_d, link_rst_q, link_rst_d;
	logic [7:0] hold_q, hold_d;
	logic       req_q, xop_q;
	logic [4:0] xaddr_q;
	logic [7:0] xdata_q;
	hport_pkg::pstate_t st_q, st_d;
	logic [4:0] addr_q, addr_d;
	logic       irq_q, irq_d;

	// parallel cycle machine and store port; serial requests share the port
	always_comb begin
		st_d       = st_q;
		addr_d     = addr_q;
		mi.we      = 1'b0;
		mi.re      = 1'b0;
		mi.addr    = addr_q;
		mi.wdata   = ad_s;
		rq1_d      = req_q;
		rq2_d      = rq1_q;
		rq3_d      = rq2_q;
		ack_d      = ack_q;
		pend_d     = 1'b0;
		hold_d     = hold_q;
		link_rst_d = 1'b0;
		irq_d      = |IRQ_SRC_IN;
		if (lat_fall) begin
			addr_d = ad_s[4:0];
		end
		unique case (st_q)
			hport_pkg::P_IDLE: begin
				if (rd_fall || (dstb_fall && rw)) begin
					st_d = hport_pkg::P_READ;
					if (!mux_m) begin
						addr_d = addr_s;
					end
				end else if (wr_fall || (dstb_fall && !rw)) begin
					st_d = hport_pkg::P_WRITE;
					if (!mux_m) begin
						addr_d = addr_s;
					end
				end
			end
			hport_pkg::P_READ: begin
				mi.re = 1'b1;
				st_d  = hport_pkg::P_DRIVE;
			end
			hport_pkg::P_DRIVE: begin
				if (rd_rise || dstb_rise || !par_on) begin
					st_d = hport_pkg::P_IDLE;
				end
			end
			hport_pkg::P_WRITE: begin
				if (wr_rise || dstb_rise) begin
					mi.we = 1'b1;
					st_d  = hport_pkg::P_IDLE;
				end else if (!par_on) begin
					st_d = hport_pkg::P_IDLE;
				end
			end
		endcase
		if (rq2_q != rq3_q) begin
			if (ser_m && !hw_m && xop_q) begin
				mi.re   = 1'b1;
				mi.addr = xaddr_q;
				pend_d  = 1'b1;
			end else begin
				mi.we    = ser_m && !hw_m;
				mi.addr  = xaddr_q;
				mi.wdata = xdata_q;
				ack_d    = ~ack_q;
			end
		end
		if (pend_q) begin
			hold_d = mi.rdata;
			ack_d  = ~ack_q;
		end
		if (!RESETN_IN) begin
			st_d       = hport_pkg::P_IDLE;
			addr_d     = hport_pkg::ADDR_RST;
			rq1_d      = 1'b0;
			rq2_d      = 1'b0;
			rq3_d      = 1'b0;
			ack_d      = 1'b0;
			pend_d     = 1'b0;
			hold_d     = hport_pkg::BYTE_RST;
			link_rst_d = 1'b1;
			irq_d      = 1'b0;
		end
	end

	always_ff @(posedge CLK_IN) begin
		st_q       <= st_d;
		addr_q     <= addr_d;
		rq1_q      <= rq1_d;
		rq2_q      <= rq2_d;
		rq3_q      <= rq3_d;
		ack_q      <= ack_d;
		pend_q     <= pend_d;
		hold_q     <= hold_d;
		link_rst_q <= link_rst_d;
		irq_q      <= irq_d;
	end

	// parallel outputs; ready waits only on the store read, acknowledge is low through drive and write
	assign AD_OUT    = mi.rdata;
	assign AD_OE_OUT = (st_q == hport_pkg::P_DRIVE);
	assign READY_ACK_OUT = dstb_m ? !(st_q == hport_pkg::P_DRIVE || st_q == hport_pkg::P_WRITE)
		: !(st_q == hport_pkg::P_READ);
	assign INT_N_OUT    = 1'b0;
	assign INT_N_OE_OUT = irq_q;

	// link side: frame state, cleared whenever select is high
	logic [4:0] cnt_q, cnt_d;
	logic [7:0] sh_q, sh_d, cmd_q, cmd_d, tx_q, tx_d, byte_in;
	logic       rd_q, rd_d, neg_q, neg_d, idle_l;
	logic       a1_q, a1_d, a2_q, a2_d, e1_q, e1_d, e2_q, e2_d;
	logic       req_d, xop_d;
	logic [4:0] xaddr_d;
	logic [7:0] xdata_d;

	assign idle_l  = (a2_q == req_q);
	assign byte_in = {sh_q[6:0], SERIAL_IN_LINE_IN};

	always_comb begin
		cnt_d = (cnt_q == hport_pkg::FRAME_END) ? cnt_q : cnt_q + 5'h01;
		sh_d  = byte_in;
		cmd_d = cmd_q;
		rd_d  = rd_q;
		tx_d  = (cnt_q >= hport_pkg::CMD_BITS) ? {tx_q[6:0], 1'b0} : tx_q;
		neg_d = tx_q[7];
		// held word is only trusted once the previous request was acknowledged
		if (cnt_q == hport_pkg::CMD_BITS - 5'h01) begin
			cmd_d = byte_in;
			rd_d  = byte_in[7];
			tx_d  = idle_l ? hold_q : hport_pkg::BYTE_RST;
		end
	end

	always_ff @(posedge SHIFT_CLK_IN or posedge SERIAL_CS_N_IN) begin
		if (SERIAL_CS_N_IN) begin
			cnt_q <= hport_pkg::CNT_RST;
			sh_q  <= hport_pkg::BYTE_RST;
			cmd_q <= hport_pkg::BYTE_RST;
			tx_q  <= hport_pkg::BYTE_RST;
			rd_q  <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			sh_q  <= sh_d;
			cmd_q <= cmd_d;
			tx_q  <= tx_d;
			rd_q  <= rd_d;
		end
	end

	// falling-edge launch copy of the transmit bit
	always_ff @(negedge SHIFT_CLK_IN or posedge SERIAL_CS_N_IN) begin
		if (SERIAL_CS_N_IN) begin
			neg_q <= 1'b0;
		end else begin
			neg_q <= neg_d;
		end
	end

	// request toggle and words; a busy core drops the new request
	always_comb begin
		a1_d    = ack_q;
		a2_d    = a1_q;
		e1_d    = EDGE_SELECT_PIN_IN;
		e2_d    = e1_q;
		req_d   = req_q;
		xop_d   = xop_q;
		xaddr_d = xaddr_q;
		xdata_d = xdata_q;
		if (idle_l && cnt_q == hport_pkg::CMD_BITS - 5'h01 && byte_in[7]) begin
			req_d   = ~req_q;
			xop_d   = 1'b1;
			xaddr_d = byte_in[4:0];
		end else if (idle_l && cnt_q == hport_pkg::FRAME_END - 5'h01 && !rd_q) begin
			req_d   = ~req_q;
			xop_d   = 1'b0;
			xaddr_d = cmd_q[4:0];
			xdata_d = byte_in;
		end
	end

	always_ff @(posedge SHIFT_CLK_IN or posedge link_rst_q) begin
		if (link_rst_q) begin
			a1_q    <= 1'b0;
			a2_q    <= 1'b0;
			e1_q    <= 1'b0;
			e2_q    <= 1'b0;
			req_q   <= 1'b0;
			xop_q   <= 1'b0;
			xaddr_q <= hport_pkg::ADDR_RST;
			xdata_q <= hport_pkg::BYTE_RST;
		end else begin
			a1_q    <= a1_d;
			a2_q    <= a2_d;
			e1_q    <= e1_d;
			e2_q    <= e2_d;
			req_q   <= req_d;
			xop_q   <= xop_d;
			xaddr_q <= xaddr_d;
			xdata_q <= xdata_d;
		end
	end

	assign SERIAL_OUT_LINE_OUT    = rd_q && (e2_q ? neg_q : tx_q[7]);
	assign SERIAL_OUT_LINE_OE_OUT = (cnt_q >= hport_pkg::CMD_BITS);

	// checks on the link side
	property p_launch_fall;
		@(negedge SHIFT_CLK_IN) disable iff (SERIAL_CS_N_IN)
		(e2_q && rd_q && cnt_q >= hport_pkg::CMD_BITS) |=> (SERIAL_OUT_LINE_OUT == $past(tx_q[7]));
	endproperty
	a_launch_fall: assert property (p_launch_fall) else $error("falling launch bit wrong");

	property p_sample_rise;
		@(posedge SHIFT_CLK_IN) disable iff (SERIAL_CS_N_IN)
		(cnt_q < hport_pkg::FRAME_END) |=> (sh_q[0] == $past(SERIAL_IN_LINE_IN));
	endproperty
	a_sample_rise: assert property (p_sample_rise) else $error("serial input not sampled");

	property p_write_low;
		@(posedge SHIFT_CLK_IN) disable iff (SERIAL_CS_N_IN)
		(cnt_q == hport_pkg::CMD_BITS && !rd_q) |-> (SERIAL_OUT_LINE_OE_OUT && !SERIAL_OUT_LINE_OUT) [*8];
	endproperty
	a_write_low: assert property (p_write_low) else $error("write frame output not low");

	property p_cmd_release;
		@(posedge SHIFT_CLK_IN) disable iff (SERIAL_CS_N_IN)
		(cnt_q < hport_pkg::CMD_BITS) |-> !SERIAL_OUT_LINE_OE_OUT;
	endproperty
	a_cmd_release: assert property (p_cmd_release) else $error("output driven in command byte");

	// falling clock: no rising edge follows the last bit before select goes high
	property p_frame_word;
		@(negedge SHIFT_CLK_IN) disable iff (SERIAL_CS_N_IN)
		(cnt_q == hport_pkg::FRAME_END - 5'h01 && !rd_q && idle_l)
		|=> (req_q != $past(req_q)) && (xdata_q == sh_q) && !xop_q;
	endproperty
	a_frame_word: assert property (p_frame_word) else $error("write word not issued");

	// checks on the core side
	sequence s_wait_then_go;
		!READY_ACK_OUT ##1 READY_ACK_OUT;
	endsequence
	property p_ready_wait;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		(rd_fall && st_q == hport_pkg::P_IDLE) |=> s_wait_then_go;
	endproperty
	a_ready_wait: assert property (p_ready_wait) else $error("ready wait state wrong");

	sequence s_ack_read;
		READY_ACK_OUT ##1 (!READY_ACK_OUT && AD_OE_OUT);
	endsequence
	property p_ack_read;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		(dstb_fall && rw && st_q == hport_pkg::P_IDLE) |=> s_ack_read;
	endproperty
	a_ack_read: assert property (p_ack_read) else $error("acknowledge on read wrong");

	property p_read_release;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		(st_q == hport_pkg::P_DRIVE && dstb_rise) |=> !AD_OE_OUT;
	endproperty
	a_read_release: assert property (p_read_release) else $error("read data not released");

	property p_wr_capture;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		(st_q == hport_pkg::P_WRITE && (wr_rise || dstb_rise)) |-> mi.we && (mi.wdata == ad_s);
	endproperty
	a_wr_capture: assert property (p_wr_capture) else $error("write data not captured");

	property p_mux_addr;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		lat_fall |=> (addr_q == $past(ad_s[4:0]));
	endproperty
	a_mux_addr: assert property (p_mux_addr) else $error("muxed address not latched");

	property p_nonmux_addr;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		(dstb_fall && !mux_m && st_q == hport_pkg::P_IDLE) |=> (addr_q == $past(addr_s));
	endproperty
	a_nonmux_addr: assert property (p_nonmux_addr) else $error("address bus not latched");

	property p_hw_quiet;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		hw_m [*2] |-> !AD_OE_OUT && !mi.we && (st_q == hport_pkg::P_IDLE);
	endproperty
	a_hw_quiet: assert property (p_hw_quiet) else $error("strobes acted in hardware mode");

	property p_irq_pin;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		(|IRQ_SRC_IN) |=> INT_N_OE_OUT && !INT_N_OUT;
	endproperty
	a_irq_pin: assert property (p_irq_pin) else $error("interrupt not asserted");
endmodule // host_port
`default_nettype wire

// File: verif/serial_host_model.sv
// serial host model: drives shift clock, select and input line, collects output
`timescale 1ns/1ns
`default_nettype none
module serial_host_model (
	output logic      sclk_out,
	output logic      cs_n_out,
	output logic      sdi_out,
	input  wire logic sdo_in,
	input  wire logic sdo_oe_in,
	input  wire logic esel_in
);
	// clock stands still and select stays high between frames
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b0;
		sdi_out  = 1'b0;
		// one select edge at start so the frame flops leave their unknown state
		#1;
		cs_n_out = 1'b1;
	end

	// one frame of sixteen shift cycles, command byte first, msb first
	task automatic frame(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd, output int bad);
		logic [15:0] tx;
		tx = {cmd, wd};
		rd = 8'h00;
		bad = 0;
		cs_n_out = 1'b0;
		#7;
		for (int i = 0; i < 16; i++) begin
			sdi_out = tx[15-i];
			#6;
			if (i < 8 && sdo_oe_in !== 1'b0) bad++;
			if (i >= 8 && esel_in) begin
				if (sdo_oe_in !== 1'b1) bad++;
				rd = {rd[6:0], sdo_in};
			end
			sclk_out = 1'b1;
			#6;
			if (i >= 7 && i < 15 && !esel_in) begin
				if (sdo_oe_in !== 1'b1) bad++;
				rd = {rd[6:0], sdo_in};
			end
			sclk_out = 1'b0;
		end
		#6;
		cs_n_out = 1'b1;
		// idle input line shows the inverse so no stale bit looks valid
		sdi_out = ~sdi_out;
	endtask
endmodule // serial_host_model
`default_nettype wire

// File: verif/tb_top.sv
// testbench top: parallel styles, hardware mode, serial frames and interrupt pin
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic       clk, rstn, hw, ser, sty, mux, sclk, cs_n, serial_in_line, esel, lat, rdrw, strb;
	logic [7:0] ad_drv, ad_out, ad_bus;
	logic [4:0] addr;
	logic [2:0] irq;
	logic       ad_oe, serial_out_line, sdo_oe, rdy, int_n, int_oe, int_wire;
	int         miscompares, checks;

	// shared bus: device drives when enabled, bench otherwise; interrupt has a pull-up
	assign ad_bus   = ad_oe ? ad_out : ad_drv;
	assign int_wire = int_oe ? int_n : 1'b1;

	host_port host_port_i (
		.CLK_IN(clk), .RESETN_IN(rstn), .HW_MODE_IN(hw), .SERIAL_MODE_IN(ser),
		.STROBE_STYLE_IN(sty), .BUS_MUX_SELECT_IN(mux), .SHIFT_CLK_IN(sclk),
		.SERIAL_CS_N_IN(cs_n), .SERIAL_IN_LINE_IN(serial_in_line), .EDGE_SELECT_PIN_IN(esel),
		.ADDR_LATCH_IN(lat), .RD_RW_IN(rdrw), .WRITE_OR_DATA_STROBE_N_IN(strb),
		.AD_IN(ad_bus), .ADDR_IN(addr), .IRQ_SRC_IN(irq), .AD_OUT(ad_out), .AD_OE_OUT(ad_oe),
		.SERIAL_OUT_LINE_OUT(serial_out_line), .SERIAL_OUT_LINE_OE_OUT(sdo_oe), .READY_ACK_OUT(rdy),
		.INT_N_OUT(int_n), .INT_N_OE_OUT(int_oe)
	);

	serial_host_model serial_host_model_i (
		.sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(serial_in_line),
		.sdo_in(serial_out_line), .sdo_oe_in(sdo_oe), .esel_in(esel)
	);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic results();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// one parallel cycle in the current style; read data taken off the bus wire
	task automatic par(input logic rd, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
		int lows;
		lows = 0;
		q = 8'h00;
		@(negedge clk);
		// multiplexed: upper bus bits set to junk, separate address bus inverted
		if (mux) begin
			addr = ~a;
			ad_drv = {3'b101, a};
			lat = 1'b0;
			repeat (3) @(negedge clk);
			lat = 1'b1;
		end else begin
			addr = a;
		end
		ad_drv = rd ? ~d : d;
		repeat (2) @(negedge clk);
		if (sty) begin
			rdrw = rd;
		end else begin
			rdrw = ~rd;
		end
		// separate style reads leave the write strobe high
		strb = !sty && rd;
		if (rd) begin
			for (int n = 0; n < 12 && ad_oe !== 1'b1; n++) begin
				@(negedge clk);
				if (rdy === 1'b0) lows++;
			end
			q = ad_bus;
			chk(8'(ad_oe), 8'h01);
			chk(8'(rdy), sty ? 8'h00 : 8'h01);
			if (!sty) chk(8'(lows), 8'h01);
		end else begin
			repeat (6) @(negedge clk);
			if (sty) chk(8'(rdy), 8'h00);
		end
		strb = 1'b1;
		rdrw = 1'b1;
		repeat (4) @(negedge clk);
		chk({6'h00, ad_oe, rdy}, 8'h01);
		repeat (3) @(negedge clk);
	endtask

	// every style and bus layout: write then read back, top address included
	task automatic t_modes();
		logic [7:0] q;
		for (int m = 0; m < 4; m++) begin
			@(negedge clk);
			sty = m[1];
			mux = m[0];
			repeat (4) @(negedge clk);
			par(1'b0, 5'(m * 10 + 1), 8'(8'hA0 + m * 17), q);
			par(1'b1, 5'(m * 10 + 1), 8'h00, q);
			chk(q, 8'(8'hA0 + m * 17));
		end
	endtask

	// hardware mode: strobes must leave the store untouched
	task automatic t_hw();
		logic [7:0] q;
		sty = 1'b0;
		mux = 1'b0;
		par(1'b0, 5'h05, 8'h77, q);
		hw = 1'b1;
		repeat (4) @(negedge clk);
		par(1'b0, 5'h05, 8'h11, q);
		chk({7'h00, ad_oe}, 8'h00);
		hw = 1'b0;
		repeat (4) @(negedge clk);
		par(1'b1, 5'h05, 8'h00, q);
		chk(q, 8'h77);
	endtask

	// serial write, pipelined reads on both launch edges, parallel cross-check
	task automatic t_ser();
		logic [7:0] q;
		int bad;
		ser = 1'b1;
		repeat (4) @(negedge clk);
		serial_host_model_i.frame(8'h09, 8'h3C, q, bad);
		chk(q, 8'h00);
		chk(8'(bad), 8'h00);
		#500;
		serial_host_model_i.frame(8'h89, 8'h00, q, bad);
		chk(8'(bad), 8'h00);
		#500;
		serial_host_model_i.frame(8'h89, 8'h00, q, bad);
		chk(q, 8'h3C);
		chk(8'(bad), 8'h00);
		esel = 1'b0;
		#500;
		serial_host_model_i.frame(8'h89, 8'h00, q, bad);
		chk(q, 8'h3C);
		chk(8'(bad), 8'h00);
		esel = 1'b1;
		@(negedge clk);
		ser = 1'b0;
		repeat (4) @(negedge clk);
		par(1'b1, 5'h09, 8'h00, q);
		chk(q, 8'h3C);
	endtask

	// each source alone pulls the shared pin low one cycle later
	task automatic t_irq();
		for (int i = 0; i < 3; i++) begin
			@(negedge clk);
			irq = 3'(1 << i);
			@(negedge clk);
			chk(8'(int_wire), 8'h00);
			irq = 3'h0;
			@(negedge clk);
			chk(8'(int_wire), 8'h01);
		end
	endtask

	initial begin
		{hw, ser, sty, mux, rstn} = 5'h00;
		{esel, lat, rdrw, strb} = 4'hF;
		ad_drv = 8'h00;
		addr = 5'h00;
		irq = 3'h0;
		miscompares = 0;
		checks = 0;
		repeat (8) @(negedge clk);
		rstn = 1'b1;
		repeat (3) @(negedge clk);
		chk({5'h00, ad_oe, rdy, int_oe}, 8'h02);
		t_modes();
		t_hw();
		t_ser();
		t_irq();
		results();
	end

	// watchdog: the whole run needs well under a tenth of this span
	initial begin
		#400000;
		miscompares++;
		results();
	end
endmodule // tb_top
`default_nettype wire
